// file: rtl/vxp_regs.sv
`timescale 1ns/1ps
`include "vxp_params.svh"
module vxp_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host i/o cycle and standard register indexes
  input wire vxp_pkg::vxp_io_req_t io_req,
  input wire vxp_pkg::vxp_std_idx_t std_idx,
  // extension index and data port read answer
  output logic [7:0] ext_rdata,
  output logic ext_rvalid,
  // standard register write gate
  output logic std_wr_en,
  output logic [7:0] std_wr_mask,
  // palette interface
  output logic palette_read_strobe_n,
  output logic palette_write_strobe_n,
  output logic pal_state_wr,
  // status sources and input status bits
  input wire vxp_pkg::vxp_vid_stat_t vid_stat,
  input wire logic [1:0] mono_gfx_cfg,
  output logic [7:0] ist1_bits,
  // interrupt pin
  input wire logic irq_enable,
  input wire logic irq_active,
  input wire logic bus_is_pc,
  output logic irq_o,
  output logic irq_oe_b,
  // emulation and alternate timing
  input wire logic lowres_mode,
  output vxp_pkg::vxp_emu_t emu_mode,
  output logic alt_sel,
  output logic [7:0] alt_total,
  output logic [7:0] alt_disp_end,
  output logic [7:0] alt_sync_start,
  output logic [4:0] alt_sync_end,
  output logic [1:0] alt_sync_delay,
  output logic [7:0] alt_blank_start,
  output logic [6:0] alt_blank_end,
  output logic [1:0] alt_de_skew,
  output logic alt_split_enh,
  output logic [7:0] alt_row_offset,
  // memory path control
  output logic crt_wrap_all,
  output logic ext_seq_timing,
  output vxp_pkg::vxp_wbm_t write_bit_mask
);
  import vxp_pkg::*;

  // merge new bits under a writable mask
  function automatic logic [7:0] vxp_merge(input logic [7:0] old, input logic [7:0] wd,
                                            input logic [7:0] msk);
    vxp_merge = (old & ~msk) | (wd & msk);
  endfunction : vxp_merge

  // address is one of a pair of ports
  function automatic logic vxp_pair(input logic [15:0] a, input logic [15:0] p0,
                                    input logic [15:0] p1);
    vxp_pair = (a == p0) || (a == p1);
  endfunction : vxp_pair

  // extension index and data port decode
  logic [6:0] index_q;
  logic [6:0] index_d;
  logic idx_port;
  logic dat_port;
  logic dat_wr;
  logic dat_rd;
  // both mono and colour copies are live; address select is the host's job
  always_comb begin
    idx_port = vxp_pair(io_req.addr, `VXP_P_EXT_M_IDX, `VXP_P_EXT_C_IDX);
    dat_port = vxp_pair(io_req.addr, `VXP_P_EXT_M_DAT, `VXP_P_EXT_C_DAT);
    dat_wr = dat_port & io_req.wr;
    dat_rd = dat_port & io_req.rd;
    index_d = index_q;
    if (idx_port && io_req.wr) begin
      index_d = io_req.wdata[6:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      index_q <= 7'h00;
    end else begin
      index_q <= index_d;
    end
  end

  // control registers
  logic [7:0] emu_q, emu_d;
  logic [7:0] wp_q, wp_d;
  logic [7:0] te_q, te_d;
  logic [7:0] ade_q, ade_d;
  logic [7:0] ass_q, ass_d;
  logic [7:0] ase_q, ase_d;
  logic [7:0] aht_q, aht_d;
  logic [7:0] abs_q, abs_d;
  logic [7:0] abe_q, abe_d;
  logic [7:0] aof_q, aof_d;
  logic [7:0] if2_q, if2_d;
  logic [7:0] wm_q, wm_d;

  // only the data port write at the selected index changes a register
  always_comb begin
    emu_d = emu_q;
    wp_d = wp_q;
    te_d = te_q;
    ade_d = ade_q;
    ass_d = ass_q;
    ase_d = ase_q;
    aht_d = aht_q;
    abs_d = abs_q;
    abe_d = abe_q;
    aof_d = aof_q;
    if2_d = if2_q;
    wm_d = wm_q;
    if (dat_wr) begin
      unique case (index_q)
        `VXP_IDX_EMU: emu_d = vxp_merge(emu_q, io_req.wdata, `VXP_WMSK_EMU);
        `VXP_IDX_WP: wp_d = vxp_merge(wp_q, io_req.wdata, `VXP_WMSK_WP);
        `VXP_IDX_TE: te_d = vxp_merge(te_q, io_req.wdata, `VXP_WMSK_TE);
        `VXP_IDX_ADE: ade_d = io_req.wdata;
        `VXP_IDX_ASS: ass_d = io_req.wdata;
        `VXP_IDX_ASE: ase_d = io_req.wdata;
        `VXP_IDX_AHT: aht_d = io_req.wdata;
        `VXP_IDX_ABS: abs_d = io_req.wdata;
        `VXP_IDX_ABE: abe_d = io_req.wdata;
        `VXP_IDX_AOF: aof_d = io_req.wdata;
        `VXP_IDX_IF2: if2_d = vxp_merge(if2_q, io_req.wdata, `VXP_WMSK_IF2);
        `VXP_IDX_WM: wm_d = vxp_merge(wm_q, io_req.wdata, `VXP_WMSK_WM);
        default: ; // status is read-clear; other indexes belong elsewhere
      endcase
    end
  end

  // every extension bit starts cleared so the chip powers up plain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      emu_q <= `VXP_RST_REG;
      wp_q <= `VXP_RST_REG;
      te_q <= `VXP_RST_REG;
      ade_q <= `VXP_RST_REG;
      ass_q <= `VXP_RST_REG;
      ase_q <= `VXP_RST_REG;
      aht_q <= `VXP_RST_REG;
      abs_q <= `VXP_RST_REG;
      abe_q <= `VXP_RST_REG;
      aof_q <= `VXP_RST_REG;
      if2_q <= `VXP_RST_REG;
      wm_q <= `VXP_RST_REG;
    end else begin
      emu_q <= emu_d;
      wp_q <= wp_d;
      te_q <= te_d;
      ade_q <= ade_d;
      ass_q <= ass_d;
      ase_q <= ase_d;
      aht_q <= aht_d;
      abs_q <= abs_d;
      abe_q <= abe_d;
      aof_q <= aof_d;
      if2_q <= if2_d;
      wm_q <= wm_d;
    end
  end

  // i/o trap detection and read-clear status
  logic [5:0] ts_q, ts_d;
  logic [5:0] hit;
  logic acc;
  logic crt_dat;
  // a trap counts reads and writes alike
  always_comb begin
    acc = io_req.rd | io_req.wr;
    crt_dat = vxp_pair(io_req.addr, `VXP_P_CRT_M_DAT, `VXP_P_CRT_C_DAT);
    hit[0] = vxp_pair(io_req.addr, `VXP_P_CRT_M_IDX, `VXP_P_CRT_M_DAT);
    hit[1] = vxp_pair(io_req.addr, `VXP_P_MONO_MODE, `VXP_P_MONO_CFG);
    hit[2] = (io_req.addr[15:4] == `VXP_P_CX_HI);
    hit[3] = vxp_pair(io_req.addr, `VXP_P_CRT_C_IDX, `VXP_P_CRT_C_DAT);
    hit[4] = vxp_pair(io_req.addr, `VXP_P_CLR_MODE, `VXP_P_CLR_SEL);
    // crtc data access at 00-0b or 10-18
    hit[5] = crt_dat && (std_idx.crtc <= 8'h0b ||
             (std_idx.crtc >= 8'h10 && std_idx.crtc <= 8'h18));
    // set wins over the read clear, so an event in the read cycle survives
    ts_d = ts_q;
    if (dat_rd && index_q == `VXP_IDX_TS) begin
      ts_d = 6'h00;
    end
    if (acc) begin
      ts_d = ts_d | (hit & te_q[5:0]);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts_q <= 6'h00;
    end else begin
      ts_q <= ts_d;
    end
  end

  // read path: contents come back even when protected
  logic [7:0] rd_d;
  logic [7:0] rdata_q;
  logic rvalid_q;
  always_comb begin
    unique case (index_q)
      `VXP_IDX_EMU: rd_d = {emu_q[7:4], mono_gfx_cfg, emu_q[1:0]};
      `VXP_IDX_WP: rd_d = {1'b0, wp_q[6:0]};
      `VXP_IDX_TE: rd_d = {2'b00, te_q[5:0]};
      `VXP_IDX_TS: rd_d = {2'b00, ts_q};
      `VXP_IDX_ADE: rd_d = ade_q;
      `VXP_IDX_ASS: rd_d = ass_q;
      `VXP_IDX_ASE: rd_d = ase_q;
      `VXP_IDX_AHT: rd_d = aht_q;
      `VXP_IDX_ABS: rd_d = abs_q;
      `VXP_IDX_ABE: rd_d = abe_q;
      `VXP_IDX_AOF: rd_d = aof_q;
      `VXP_IDX_IF2: rd_d = if2_q & `VXP_WMSK_IF2;
      `VXP_IDX_WM: rd_d = wm_q & `VXP_WMSK_WM;
      default: rd_d = 8'h00; // unimplemented here, reads zero
    endcase
  end

  // index port reads answer too; bit 7 of the index is always zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= (dat_port | idx_port) & io_req.rd;
      if (dat_rd) begin
        rdata_q <= rd_d;
      end else if (idx_port && io_req.rd) begin
        rdata_q <= {1'b0, index_q};
      end
    end
  end

  // write protection of standard registers
  logic [7:0] prot_mask;
  logic pal_sel;
  logic std_wr_en_q;
  logic [7:0] std_wr_mask_q;
  logic pal_rd_n_q;
  logic pal_wr_n_q;
  logic pal_state_q;
  vxp_wp_dec u_wp_dec (
    .wp(wp_q[6:0]),
    .req(io_req),
    .idx(std_idx),
    .mask(prot_mask)
  );

  // own extension ports never pass through this gate
  always_comb begin
    pal_sel = (io_req.addr >= `VXP_P_PAL_LO) && (io_req.addr <= `VXP_P_PAL_HI);
  end

  // the gate lags the host cycle by one clock; the standard file
  // must hold its write until it sees std_wr_en
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      std_wr_en_q <= 1'b0;
      std_wr_mask_q <= 8'h00;
      pal_rd_n_q <= 1'b1;
      pal_wr_n_q <= 1'b1;
      pal_state_q <= 1'b0;
    end else begin
      std_wr_en_q <= io_req.wr & ~dat_port & ~idx_port;
      std_wr_mask_q <= prot_mask;
      pal_rd_n_q <= ~(pal_sel & io_req.rd & ~wp_q[5]);
      pal_wr_n_q <= ~(pal_sel & io_req.wr & ~wp_q[5]);
      pal_state_q <= pal_sel & io_req.wr & ~wp_q[5];
    end
  end

  // input status 1 multiplexing
  logic [7:0] ist1_d;
  logic [7:0] ist1_q;
  // sources are on this clock already, no resync needed
  always_comb begin
    ist1_d = 8'h00;
    ist1_d[0] = emu_q[`VXP_EMU_DE_SEL] ? vid_stat.hsync : vid_stat.disp_en;
    ist1_d[3] = emu_q[`VXP_EMU_VR_SEL] ? vid_stat.video : vid_stat.vretrace;
    // set bit enables vsync here, as the mono text modes want
    ist1_d[7] = emu_q[`VXP_EMU_VS_EN] & vid_stat.vsync;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ist1_q <= 8'h00;
    end else begin
      ist1_q <= ist1_d;
    end
  end

  // interrupt pin drive
  logic irq_d, irq_oe_b_d;
  logic irq_q, irq_oe_b_q;
  // micro channel ignores the drive-mode bit: low only when pending
  always_comb begin
    irq_d = 1'b0;
    irq_oe_b_d = 1'b1;
    if (!bus_is_pc) begin
      irq_oe_b_d = ~(irq_enable & irq_active);
    end else if (emu_q[`VXP_EMU_IRQ]) begin
      irq_oe_b_d = ~irq_enable;
      irq_d = irq_enable & irq_active;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
      irq_oe_b_q <= 1'b1;
    end else begin
      irq_q <= irq_d;
      irq_oe_b_q <= irq_oe_b_d;
    end
  end

  // alternate timing select
  logic alt_sel_q;
  // colour graphics only when low-res; mono graphics always
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alt_sel_q <= 1'b0;
    end else begin
      alt_sel_q <= (emu_q[1:0] == VXP_EMU_MONO_GFX) ||
                   ((emu_q[1:0] == VXP_EMU_CLR_GFX) && lowres_mode);
    end
  end

  // outputs
  assign ext_rdata = rdata_q;
  assign ext_rvalid = rvalid_q;
  assign std_wr_en = std_wr_en_q;
  assign std_wr_mask = std_wr_mask_q;
  assign palette_read_strobe_n = pal_rd_n_q;
  assign palette_write_strobe_n = pal_wr_n_q;
  assign pal_state_wr = pal_state_q;
  assign ist1_bits = ist1_q;
  assign irq_o = irq_q;
  assign irq_oe_b = irq_oe_b_q;
  assign emu_mode = vxp_emu_t'(emu_q[1:0]);
  assign alt_sel = alt_sel_q;
  // alternate set mirrors the standard horizontal fields
  assign alt_total = aht_q;
  assign alt_disp_end = ade_q;
  assign alt_sync_start = ass_q;
  assign alt_sync_end = ase_q[4:0];
  assign alt_sync_delay = ase_q[6:5];
  assign alt_blank_start = abs_q;
  assign alt_blank_end = {ase_q[`VXP_ASE_BE6], 1'b0, abe_q[4:0]};
  assign alt_de_skew = abe_q[6:5];
  assign alt_split_enh = abe_q[`VXP_ABE_SPLIT];
  assign alt_row_offset = aof_q;
  assign crt_wrap_all = if2_q[`VXP_IF2_WRAP];
  assign ext_seq_timing = if2_q[`VXP_IF2_XSEQ];
  // rmw may run with the mask on; host must not read meanwhile
  assign write_bit_mask = {wm_q[`VXP_WM_EN], wm_q[2:1], wm_q[`VXP_WM_RMW]};
endmodule : vxp_regs

// file: rtl/vxp_params.svh
// Contract
// - emulation bits 1-0 pick mode; 3-2 read-only
// - bits 4,5 steer input status bits 0,3
// - bit 6 gates vsync onto status bit 7
// - bit 7 and bus type shape interrupt drive
// - protect bit 1 protects; bit 7 reads zero
// - bit 0 guards sequencer, graphics, attribute groups
// - bit 1 guards cursor size, character height
// - bit 2 guards split, scroll, mode fields
// - bit 3 guards vertical timing fields
// - bit 4 guards misc output, feature control
// - bit 5 blocks palette strobes and state
// - bit 6 or retrace-end bit 7 guards timing
// - trap enables arm traps on listed targets
// - trap enable zero on reset; bits 7-6 reserved
// - status bits set on access; read clears
// - alternate registers replace horizontal set in emulation; selected in mono graphics and low-res colour graphics only
// - sync end bit 7 is blank end bit 6
// - blank end bit 7 picks split-screen behaviour
// - wrap bit and extended sequencer timing bit
// - bit-mask enable and mask source select
// - read-modify-write conversion; host avoids reads then
`ifndef VXP_PARAMS_SVH
`define VXP_PARAMS_SVH
// extension register indexes
`define VXP_IDX_EMU 7'h14
`define VXP_IDX_WP 7'h15
`define VXP_IDX_TE 7'h16
`define VXP_IDX_TS 7'h17
`define VXP_IDX_ADE 7'h18
`define VXP_IDX_ASS 7'h19
`define VXP_IDX_ASE 7'h1a
`define VXP_IDX_AHT 7'h1b
`define VXP_IDX_ABS 7'h1c
`define VXP_IDX_ABE 7'h1d
`define VXP_IDX_AOF 7'h1e
`define VXP_IDX_IF2 7'h20
`define VXP_IDX_WM 7'h23
// host i/o ports
`define VXP_P_EXT_M_IDX 16'h03b6
`define VXP_P_EXT_M_DAT 16'h03b7
`define VXP_P_EXT_C_IDX 16'h03d6
`define VXP_P_EXT_C_DAT 16'h03d7
`define VXP_P_CRT_M_IDX 16'h03b4
`define VXP_P_CRT_M_DAT 16'h03b5
`define VXP_P_CRT_C_IDX 16'h03d4
`define VXP_P_CRT_C_DAT 16'h03d5
`define VXP_P_MONO_MODE 16'h03b8
`define VXP_P_MONO_CFG 16'h03bf
`define VXP_P_CLR_MODE 16'h03d8
`define VXP_P_CLR_SEL 16'h03d9
`define VXP_P_CX_HI 12'h03c
`define VXP_P_ATTR 16'h03c0
`define VXP_P_MISC 16'h03c2
`define VXP_P_SEQ_DAT 16'h03c5
`define VXP_P_PAL_LO 16'h03c6
`define VXP_P_PAL_HI 16'h03c9
`define VXP_P_GFX_DAT 16'h03cf
`define VXP_P_FEAT_M 16'h03ba
`define VXP_P_FEAT_C 16'h03da
// field positions
`define VXP_EMU_DE_SEL 4
`define VXP_EMU_VR_SEL 5
`define VXP_EMU_VS_EN 6
`define VXP_EMU_IRQ 7
`define VXP_IF2_WRAP 1
`define VXP_IF2_XSEQ 3
`define VXP_WM_EN 0
`define VXP_WM_RMW 3
`define VXP_ASE_BE6 7
`define VXP_ABE_SPLIT 7
// reset value and writable-bit masks
`define VXP_RST_REG 8'h00
`define VXP_WMSK_EMU 8'hf3
`define VXP_WMSK_WP 8'h7f
`define VXP_WMSK_TE 8'h3f
`define VXP_WMSK_IF2 8'h0a
`define VXP_WMSK_WM 8'h0f
`endif

// file: rtl/vxp_pkg.sv
package vxp_pkg;
  // compatibility mode in emulation bits 1-0
  typedef enum logic [1:0] {
    VXP_EMU_STD = 2'h0,
    VXP_EMU_CLR_GFX = 2'h1,
    VXP_EMU_MONO_TXT = 2'h2,
    VXP_EMU_MONO_GFX = 2'h3
  } vxp_emu_t;
  // one host i/o cycle, valid for one clock
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } vxp_io_req_t;
  // current indexes of the standard register groups
  typedef struct packed {
    logic [7:0] seq;
    logic [7:0] gfx;
    logic [7:0] attr;
    logic [7:0] crtc;
    logic attr_data;
    logic retrace_end_lock;
  } vxp_std_idx_t;
  // raw video status from the display timing logic
  typedef struct packed {
    logic disp_en;
    logic hsync;
    logic vretrace;
    logic video;
    logic vsync;
  } vxp_vid_stat_t;
  // write path control
  typedef struct packed {
    logic en;
    logic [1:0] src;
    logic rmw;
  } vxp_wbm_t;
endpackage : vxp_pkg

// file: rtl/vxp_wp_dec.sv
`timescale 1ns/1ps
`include "vxp_params.svh"
module vxp_wp_dec (
  // protect bits and request
  input wire logic [6:0] wp,
  input wire vxp_pkg::vxp_io_req_t req,
  input wire vxp_pkg::vxp_std_idx_t idx,
  // bits a write may change
  output logic [7:0] mask
);
  import vxp_pkg::*;
  logic crt_dat;
  logic lock0;
  logic [7:0] c;
  always_comb begin
    crt_dat = (req.addr == `VXP_P_CRT_M_DAT) || (req.addr == `VXP_P_CRT_C_DAT);
    lock0 = wp[6] | idx.retrace_end_lock;
    c = idx.crtc;
    mask = 8'hff;
    if ((req.addr == `VXP_P_SEQ_DAT && idx.seq <= 8'h04) ||
        (req.addr == `VXP_P_GFX_DAT && idx.gfx <= 8'h08) ||
        (req.addr == `VXP_P_ATTR && idx.attr_data && idx.attr <= 8'h14)) begin
      mask = {8{~wp[0]}};
    end else if (req.addr == `VXP_P_MISC || req.addr == `VXP_P_FEAT_M ||
                 req.addr == `VXP_P_FEAT_C) begin
      mask = {8{~wp[4]}};
    end else if (req.addr >= `VXP_P_PAL_LO && req.addr <= `VXP_P_PAL_HI) begin
      mask = {8{~wp[5]}};
    end else if (crt_dat) begin
      unique case (c)
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06: mask = {8{~lock0}};
        8'h07: mask = {{3{~lock0}}, ~wp[2], {4{~lock0}}};
        8'h08, 8'h13, 8'h14, 8'h18: mask = {8{~wp[2]}};
        8'h09: mask = {{3{~wp[3]}}, {5{~wp[1]}}};
        8'h0a, 8'h0b: mask = {8{~wp[1]}};
        8'h10, 8'h12, 8'h15, 8'h16: mask = {8{~wp[3]}};
        8'h11: mask = {1'b1, ~wp[3], {2{~wp[2]}}, {4{~wp[3]}}};
        8'h17: mask = {{5{~wp[2]}}, ~wp[3], {2{~wp[2]}}};
        default: mask = 8'hff;
      endcase
    end
  end
endmodule : vxp_wp_dec

// file: verif/vxp_regs_sva.sv
`timescale 1ns/1ps
`include "vxp_params.svh"
module vxp_regs_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // inputs watched
  input wire vxp_pkg::vxp_io_req_t io_req,
  input wire vxp_pkg::vxp_vid_stat_t vid_stat,
  input wire logic irq_enable,
  input wire logic irq_active,
  input wire logic lowres_mode,
  // outputs watched
  input wire logic [7:0] ext_rdata,
  input wire logic ext_rvalid,
  input wire logic std_wr_en,
  input wire logic palette_write_strobe_n,
  input wire logic pal_state_wr,
  input wire logic [7:0] ist1_bits,
  input wire logic irq_o,
  input wire logic irq_oe_b,
  input wire vxp_pkg::vxp_emu_t emu_mode,
  input wire logic alt_sel
);
  import vxp_pkg::*;
  logic ext_hit;
  logic rd_ext;
  logic wr_pal;
  logic alt_want;
  // decodes, so that $past only ever sees plain signals
  assign ext_hit = io_req.addr inside {16'h03b6, 16'h03b7, 16'h03d6, 16'h03d7};
  assign rd_ext = io_req.rd && ext_hit;
  assign wr_pal = io_req.wr && io_req.addr >= `VXP_P_PAL_LO && io_req.addr <= `VXP_P_PAL_HI;
  assign alt_want = emu_mode == VXP_EMU_MONO_GFX || (emu_mode == VXP_EMU_CLR_GFX && lowres_mode);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RVALID: assert property (rd_ext |=> ext_rvalid)
    else $error("extension read not answered");
  AST_RDATA_HOLD: assert property (!ext_rvalid |-> $stable(ext_rdata))
    else $error("read data moved without a read");
  AST_STD_WR: assert property (io_req.wr |=> std_wr_en != $past(ext_hit))
    else $error("standard write gate wrong");
  AST_PAL_WR: assert property (!palette_write_strobe_n |-> $past(wr_pal))
    else $error("palette write strobe without a palette write");
  AST_PAL_STATE: assert property (pal_state_wr == !palette_write_strobe_n)
    else $error("palette state write apart from strobe");
  AST_IRQ_OFF: assert property ($past(irq_enable) == 1'b0 |-> irq_oe_b)
    else $error("interrupt driven while disabled");
  AST_IRQ_HIGH: assert property (irq_o && !irq_oe_b |-> $past(irq_active))
    else $error("interrupt high while inactive");
  AST_IST_ZERO: assert property ((ist1_bits & 8'h76) == 8'h00)
    else $error("unused status bits set");
  AST_IST_VS: assert property (ist1_bits[7] |-> $past(vid_stat.vsync))
    else $error("status bit 7 without vsync");
  AST_ALT_SEL: assert property (alt_sel == $past(alt_want))
    else $error("alternate select wrong");
endmodule : vxp_regs_sva
bind vxp_regs vxp_regs_sva chk_u (.clk, .rst_b, .io_req, .vid_stat, .irq_enable, .irq_active,
  .lowres_mode, .ext_rdata, .ext_rvalid, .std_wr_en, .palette_write_strobe_n, .pal_state_wr,
  .ist1_bits, .irq_o, .irq_oe_b, .emu_mode, .alt_sel);

// file: verif/vxp_host_mdl.sv
`timescale 1ns/1ps
module vxp_host_mdl (
  // bus clock
  input wire logic clk,
  // i/o cycle toward the device
  output vxp_pkg::vxp_io_req_t io_req
);
  import vxp_pkg::*;
  initial io_req = '0;
  // one cycle held over one rising edge; idle bus shows inverted values
  task automatic io(input logic rd, input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_req = '{rd: rd, wr: wr, addr: a, wdata: d};
    @(negedge clk);
    io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : io
  // index port first, then data port; odd indexes use the mono pair
  task automatic xwr(input logic [6:0] i, input logic [7:0] d);
    io(1'b0, 1'b1, i[0] ? 16'h03b6 : 16'h03d6, {1'b0, i});
    io(1'b0, 1'b1, i[0] ? 16'h03b7 : 16'h03d7, d);
  endtask : xwr
  task automatic xrd(input logic [6:0] i);
    io(1'b0, 1'b1, i[0] ? 16'h03b6 : 16'h03d6, {1'b0, i});
    io(1'b1, 1'b0, i[0] ? 16'h03b7 : 16'h03d7, 8'h00);
  endtask : xrd
endmodule : vxp_host_mdl

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import vxp_pkg::*;
  logic clk;
  logic rst_b;
  vxp_io_req_t io_req;
  vxp_std_idx_t std_idx;
  vxp_vid_stat_t vid_stat;
  logic irq_enable, irq_active, bus_is_pc, lowres_mode;
  logic [1:0] mono_gfx_cfg, alt_sync_delay, alt_de_skew;
  logic [7:0] ext_rdata, std_wr_mask, ist1_bits, alt_total, alt_disp_end;
  logic [7:0] alt_sync_start, alt_blank_start, alt_row_offset, r8, e;
  logic ext_rvalid, std_wr_en, palette_read_strobe_n, palette_write_strobe_n, pal_state_wr;
  logic irq_o, irq_oe_b, alt_sel, alt_split_enh, crt_wrap_all, ext_seq_timing;
  logic [4:0] alt_sync_end;
  logic [6:0] alt_blank_end;
  vxp_emu_t emu_mode;
  vxp_wbm_t write_bit_mask;
  int err_total, checks;
  logic [31:0] seed = 32'h3835521f;
  logic [7:0] mdl [0:127];
  logic [6:0] ids [14] = '{7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c,
    7'h1d, 7'h1e, 7'h20, 7'h23, 7'h30};
  logic [15:0] tp [11] = '{16'h03b4, 16'h03b5, 16'h03b8, 16'h03bf, 16'h03c2, 16'h03ce,
    16'h03d4, 16'h03d5, 16'h03d8, 16'h03d9, 16'h03da};
  vxp_regs dut_u (.clk, .rst_b, .io_req, .std_idx, .ext_rdata, .ext_rvalid, .std_wr_en,
    .std_wr_mask, .palette_read_strobe_n, .palette_write_strobe_n, .pal_state_wr, .vid_stat,
    .mono_gfx_cfg, .ist1_bits, .irq_enable, .irq_active, .bus_is_pc, .irq_o, .irq_oe_b,
    .lowres_mode, .emu_mode, .alt_sel, .alt_total, .alt_disp_end, .alt_sync_start,
    .alt_sync_end, .alt_sync_delay, .alt_blank_start, .alt_blank_end, .alt_de_skew,
    .alt_split_enh, .alt_row_offset, .crt_wrap_all, .ext_seq_timing, .write_bit_mask);
  vxp_host_mdl host_u (.clk, .io_req);
  // 25 MHz bus clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  // writable bits per index; anything else must ignore writes
  function automatic logic [7:0] wm(input logic [6:0] i);
    case (i)
      7'h14: wm = 8'hf3;
      7'h15: wm = 8'h7f;
      7'h16: wm = 8'h3f;
      7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e: wm = 8'hff;
      7'h20: wm = 8'h0a;
      7'h23: wm = 8'h0f;
      default: wm = 8'h00;
    endcase
  endfunction : wm
  function automatic logic [7:0] texp(input logic [15:0] a, input logic [7:0] c);
    texp = {2'b0, a inside {16'h03b5, 16'h03d5} && (c <= 8'h0b || (c >= 8'h10 && c <= 8'h18)),
      a inside {16'h03d8, 16'h03d9}, a inside {16'h03d4, 16'h03d5}, a[15:4] == 12'h03c,
      a inside {16'h03b8, 16'h03bf}, a inside {16'h03b4, 16'h03b5}};
  endfunction : texp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xw(input logic [6:0] i, input logic [7:0] d);
    host_u.xwr(i, d);
    mdl[i] = (mdl[i] & ~wm(i)) | (d & wm(i));
  endtask : xw
  task automatic xr(input logic [6:0] i);
    host_u.xrd(i);
    chk(8'(ext_rvalid), 8'h01);
    chk(ext_rdata, i == 7'h14 ? mdl[i] | {4'h0, mono_gfx_cfg, 2'b0} : mdl[i]);
  endtask : xr
  task automatic prot(input logic [7:0] wp, input logic [15:0] a, input logic [7:0] ci,
      input logic [7:0] si, input logic lk, input logic [7:0] ex);
    xw(7'h15, wp);
    std_idx = '{seq: si, gfx: si, attr: si, crtc: ci, attr_data: 1'b1, retrace_end_lock: lk};
    host_u.io(1'b0, 1'b1, a, rnd());
    chk(8'(std_wr_en), 8'h01);
    chk(std_wr_mask, ex);
  endtask : prot
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // hang guard, far past the test length
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("CHECK FAILED %0t watchdog", $time);
    results();
  end
  // main sequence
  initial begin
    rst_b = 1'b0;
    std_idx = '0;
    vid_stat = '0;
    {irq_enable, irq_active, bus_is_pc, lowres_mode, mono_gfx_cfg} = '0;
    mdl = '{default: 8'h00};
    repeat (5) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    foreach (ids[k]) xr(ids[k]);
    $display("reset values done");
    for (int r = 0; r < 2; r++) begin
      r8 = rnd();
      mono_gfx_cfg = r8[1:0];
      foreach (ids[k]) xw(ids[k], rnd());
      foreach (ids[k]) xr(ids[k]);
      chk({6'h0, emu_mode}, {6'h0, mdl[7'h14][1:0]});
      chk({1'b0, alt_blank_end}, {1'b0, mdl[7'h1a][7], 1'b0, mdl[7'h1d][4:0]});
      chk({5'h0, alt_split_enh, alt_de_skew}, {5'h0, mdl[7'h1d][7:5]});
      chk({6'h0, crt_wrap_all, ext_seq_timing}, {6'h0, mdl[7'h20][1], mdl[7'h20][3]});
      chk({4'h0, write_bit_mask}, {4'h0, mdl[7'h23][0], mdl[7'h23][2:1], mdl[7'h23][3]});
      chk(alt_total ^ alt_disp_end ^ alt_sync_start, mdl[7'h1b] ^ mdl[7'h18] ^ mdl[7'h19]);
      chk(alt_blank_start ^ alt_row_offset, mdl[7'h1c] ^ mdl[7'h1e]);
      chk({1'b0, alt_sync_delay, alt_sync_end}, {1'b0, mdl[7'h1a][6:0]});
    end
    $display("register access done");
    for (int k = 0; k < 16; k++) begin
      xw(7'h14, {k[3], 7'h00});
      {irq_active, irq_enable, bus_is_pc} = k[2:0];
      @(negedge clk);
      e[0] = k[1] && (k[0] ? k[3] : k[2]);
      chk({7'h0, irq_oe_b}, {7'h0, !e[0]});
      if (e[0]) chk({7'h0, irq_o}, {7'h0, k[0] && k[3] && k[2]});
      xw(7'h14, {1'b0, k[2:0], 4'h0});
      r8 = rnd();
      vid_stat = r8[4:0];
      @(negedge clk);
      chk(ist1_bits, {k[2] & r8[0], 3'b0, k[1] ? r8[1] : r8[2], 2'b0, k[0] ? r8[3] : r8[4]});
      lowres_mode = k[2];
      xw(7'h14, {6'h0, k[1:0]});
      @(negedge clk);
      chk({7'h0, alt_sel}, {7'h0, k[1:0] == 2'd3 || (k[1:0] == 2'd1 && k[2])});
    end
    $display("interrupt and status done");
    for (int k = 0; k < 16; k++) begin
      xw(7'h16, rnd());
      r8 = rnd();
      std_idx.crtc = {3'b0, r8[4:0]};
      e = tp[rnd() % 11][7:0];
      host_u.io(r8[7], !r8[7], {8'h03, e}, rnd());
      mdl[7'h17] = texp({8'h03, e}, std_idx.crtc) & mdl[7'h16];
      xr(7'h17);
      mdl[7'h17] = 8'h00;
      xr(7'h17);
    end
    xw(7'h16, 8'h00);
    $display("traps done");
    prot(8'h00, `VXP_P_SEQ_DAT, 8'h00, 8'h04, 1'b0, 8'hff);
    prot(8'h01, `VXP_P_SEQ_DAT, 8'h00, 8'h04, 1'b0, 8'h00);
    prot(8'h01, `VXP_P_SEQ_DAT, 8'h00, 8'h05, 1'b0, 8'hff);
    prot(8'h01, `VXP_P_GFX_DAT, 8'h00, 8'h08, 1'b0, 8'h00);
    prot(8'h01, `VXP_P_ATTR, 8'h00, 8'h14, 1'b0, 8'h00);
    prot(8'h02, `VXP_P_CRT_C_DAT, 8'h09, 8'h00, 1'b0, 8'he0);
    prot(8'h02, `VXP_P_CRT_M_DAT, 8'h0b, 8'h00, 1'b0, 8'h00);
    prot(8'h04, `VXP_P_CRT_C_DAT, 8'h07, 8'h00, 1'b0, 8'hef);
    prot(8'h04, `VXP_P_CRT_C_DAT, 8'h11, 8'h00, 1'b0, 8'hcf);
    prot(8'h04, `VXP_P_CRT_C_DAT, 8'h17, 8'h00, 1'b0, 8'h04);
    prot(8'h08, `VXP_P_CRT_C_DAT, 8'h09, 8'h00, 1'b0, 8'h1f);
    prot(8'h08, `VXP_P_CRT_M_DAT, 8'h11, 8'h00, 1'b0, 8'hb0);
    prot(8'h08, `VXP_P_CRT_C_DAT, 8'h17, 8'h00, 1'b0, 8'hfb);
    prot(8'h10, `VXP_P_MISC, 8'h00, 8'h00, 1'b0, 8'h00);
    prot(8'h10, `VXP_P_FEAT_C, 8'h00, 8'h00, 1'b0, 8'h00);
    prot(8'h40, `VXP_P_CRT_C_DAT, 8'h03, 8'h00, 1'b0, 8'h00);
    prot(8'h40, `VXP_P_CRT_C_DAT, 8'h07, 8'h00, 1'b0, 8'h10);
    prot(8'h00, `VXP_P_CRT_C_DAT, 8'h05, 8'h00, 1'b1, 8'h00);
    xr(7'h15);
    for (int k = 0; k < 4; k++) begin
      xw(7'h15, {2'b0, k[1], 5'h0});
      host_u.io(!k[0], k[0], k[0] ? `VXP_P_PAL_HI : `VXP_P_PAL_LO, rnd());
      e[0] = !k[1];
      chk({5'h0, palette_read_strobe_n, palette_write_strobe_n, pal_state_wr},
        {5'h0, !(e[0] && !k[0]), !(e[0] && k[0]), e[0] && k[0]});
    end
    $display("protection done");
    results();
  end
endmodule : tb_top
